// *** rtl/bdg_host.sv ***
// Host end of the background debug link: sends commands, waits for
// acknowledges and aborts a pending command by a long low pulse.
// Assumes a synchronous pin level and a bdg_target at the far end.
//
// Functional notes
// - Target itself starts each acknowledge falling edge.
// - One acknowledge outstanding; abort before next.
// - Low power entry discards command, no acknowledge.
// - Host times out missing acknowledge itself.
// - Any missing acknowledge is followed by abort.
// - Abort: 128 serial cycles low, speedup high.
// - Long low makes target sync, cancels command.
// - After sync reply, host may send again.
// - Running access completes; only acknowledge suppressed.
// - High is driven only during speedup pulses.
`timescale 1ns/1ns
`include "bdg_params.svh"
module bdg_host #(
    parameter int SER_DIV  = `BDG_SER_DIV,
    parameter int ACK_TMO  = `BDG_ACK_TMO_SER,
    parameter int SYNC_TMO = `BDG_SYNC_TMO_SER
) (
    input  wire logic    CLK,
    input  wire logic    RESETN,
    bdg_link_if.host     LINK,
    input  wire logic    CMD_REQ,
    input  wire logic    ABORT_REQ,
    output logic         READY,
    output logic         ACK_SEEN,
    output logic         ACK_MISSING,
    output logic         ABORT_DONE
);
    import bdg_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // Derived clock counts.

    // Every duration is a serial cycle count scaled by the divider.
    localparam logic [`BDG_CNT_W-1:0] CMD_LEN   = `BDG_CNT_W'(`BDG_CMD_SER * SER_DIV - 1);
    localparam logic [`BDG_CNT_W-1:0] ABORT_LEN = `BDG_CNT_W'(`BDG_ABORT_SER * SER_DIV - 1);
    localparam logic [`BDG_CNT_W-1:0] SPD_LEN   = `BDG_CNT_W'(`BDG_SPEED_SER * SER_DIV - 1);
    localparam logic [`BDG_CNT_W-1:0] ACK_LEN   = `BDG_CNT_W'(ACK_TMO * SER_DIV - 1);
    localparam logic [`BDG_CNT_W-1:0] SYNC_LEN  = `BDG_CNT_W'(SYNC_TMO * SER_DIV - 1);

    bdg_host_state_t         state_reg;
    logic [`BDG_CNT_W-1:0]   tmr_reg;
    logic                    o_reg;
    logic                    oe_n_reg;
    logic                    tmr_zero;

    // The pin is driven only from flip-flops.
    assign LINK.host_o    = o_reg;
    assign LINK.host_oe_n = oe_n_reg;
    assign tmr_zero       = (tmr_reg == '0);

    ////////////////////////////////////////////////////////////////////////////
    // Phase timer.

    // Counts down the length of the phase in progress, stopping at zero.
    always_ff @(posedge CLK) begin
        if (!RESETN) begin
            tmr_reg <= '0;
        end else begin
            unique case (state_reg)
                H_IDLE: begin
                    if (ABORT_REQ) begin
                        tmr_reg <= ABORT_LEN;
                    end else if (CMD_REQ) begin
                        tmr_reg <= CMD_LEN;
                    end
                end
                H_CMD: begin
                    tmr_reg <= tmr_zero ? SPD_LEN : tmr_reg - 1'b1;
                end
                H_CSPEED: begin
                    tmr_reg <= tmr_zero ? ACK_LEN : tmr_reg - 1'b1;
                end
                H_WACK: begin
                    if (tmr_zero || ABORT_REQ) begin
                        tmr_reg <= ABORT_LEN;
                    end else begin
                        tmr_reg <= tmr_reg - 1'b1;
                    end
                end
                H_ABLO: begin
                    tmr_reg <= tmr_zero ? SPD_LEN : tmr_reg - 1'b1;
                end
                H_ABSPD: begin
                    tmr_reg <= tmr_zero ? SYNC_LEN : tmr_reg - 1'b1;
                end
                H_SWAIT: begin
                    if (!tmr_zero) begin
                        tmr_reg <= tmr_reg - 1'b1;
                    end
                end
                H_ACKLO, H_SREP: begin
                    tmr_reg <= '0;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Handshake state machine.

    // Sequences command, acknowledge wait and abort, and drives the pin.
    always_ff @(posedge CLK) begin
        if (!RESETN) begin
            state_reg   <= H_IDLE;
            o_reg       <= 1'b1;
            oe_n_reg    <= 1'b1;
            READY       <= 1'b1;
            ACK_SEEN    <= 1'b0;
            ACK_MISSING <= 1'b0;
            ABORT_DONE  <= 1'b0;
        end else begin
            ACK_SEEN    <= 1'b0;
            ACK_MISSING <= 1'b0;
            ABORT_DONE  <= 1'b0;
            unique case (state_reg)
                H_IDLE: begin
                    if (ABORT_REQ) begin
                        o_reg     <= 1'b0;
                        oe_n_reg  <= 1'b0;
                        READY     <= 1'b0;
                        state_reg <= H_ABLO;
                    end else if (CMD_REQ) begin
                        o_reg     <= 1'b0;
                        oe_n_reg  <= 1'b0;
                        READY     <= 1'b0;
                        state_reg <= H_CMD;
                    end
                end
                H_CMD: begin
                    if (tmr_zero) begin
                        o_reg     <= 1'b1;
                        state_reg <= H_CSPEED;
                    end
                end
                H_CSPEED: begin
                    if (tmr_zero) begin
                        oe_n_reg  <= 1'b1;
                        state_reg <= H_WACK;
                    end
                end
                H_WACK: begin
                    if (!LINK.pin) begin
                        state_reg <= H_ACKLO;
                    end else if (tmr_zero || ABORT_REQ) begin
                        ACK_MISSING <= tmr_zero;
                        o_reg       <= 1'b0;
                        oe_n_reg    <= 1'b0;
                        state_reg   <= H_ABLO;
                    end
                end
                H_ACKLO: begin
                    if (LINK.pin) begin
                        ACK_SEEN  <= 1'b1;
                        READY     <= 1'b1;
                        state_reg <= H_IDLE;
                    end
                end
                H_ABLO: begin
                    if (tmr_zero) begin
                        o_reg     <= 1'b1;
                        state_reg <= H_ABSPD;
                    end
                end
                H_ABSPD: begin
                    if (tmr_zero) begin
                        oe_n_reg  <= 1'b1;
                        state_reg <= H_SWAIT;
                    end
                end
                H_SWAIT: begin
                    if (!LINK.pin) begin
                        state_reg <= H_SREP;
                    end else if (tmr_zero) begin
                        ABORT_DONE <= 1'b1;
                        READY      <= 1'b1;
                        state_reg  <= H_IDLE;
                    end
                end
                H_SREP: begin
                    if (LINK.pin) begin
                        ABORT_DONE <= 1'b1;
                        READY      <= 1'b1;
                        state_reg  <= H_IDLE;
                    end
                end
            endcase
        end
    end
endmodule

// *** rtl/bdg_params.svh ***
// Timing constants of the background debug abort handshake.
// Assumes inclusion by bare name from both link ends.
`ifndef BDG_PARAMS_SVH
`define BDG_PARAMS_SVH
`define BDG_CNT_W        16
`define BDG_SER_DIV      8
`define BDG_ABORT_SER    128
`define BDG_CMD_SER      4
`define BDG_CMD_MIN_SER  2
`define BDG_ACK_SER      16
`define BDG_SPEED_SER    1
`define BDG_GUARD_SER    2
`define BDG_REPLY_SER    16
`define BDG_ACK_TMO_SER  256
`define BDG_SYNC_TMO_SER 256
`endif

// *** rtl/bdg_pkg.sv ***
// State types of both ends of the background debug handshake.
// Assumes no surroundings beyond the compiler.
package bdg_pkg;
    typedef enum logic [6:0] {
        T_IDLE   = 7'h01,
        T_PEND   = 7'h02,
        T_ACK    = 7'h04,
        T_SPEED  = 7'h08,
        T_SYNC   = 7'h10,
        T_REPLY  = 7'h20,
        T_RSPEED = 7'h40
    } bdg_tgt_state_t;
    typedef enum logic [8:0] {
        H_IDLE   = 9'h001,
        H_CMD    = 9'h002,
        H_CSPEED = 9'h004,
        H_WACK   = 9'h008,
        H_ACKLO  = 9'h010,
        H_ABLO   = 9'h020,
        H_ABSPD  = 9'h040,
        H_SWAIT  = 9'h080,
        H_SREP   = 9'h100
    } bdg_host_state_t;
endpackage

// *** rtl/bdg_link_if.sv ***
// Single wire background debug link between host and target.
// Assumes both ends drive with active low output enables.
`timescale 1ns/1ns
interface bdg_link_if;
    logic host_o;
    logic host_oe_n;
    logic tgt_o;
    logic tgt_oe_n;
    logic pin;
    logic conflict;
    // Any low drive pulls the wire down, otherwise the pull-up holds it high.
    assign pin = !((!host_oe_n && !host_o) || (!tgt_oe_n && !tgt_o));
    // Opposite drives at once mean a speedup pulse against a low.
    assign conflict = !host_oe_n && !tgt_oe_n && (host_o != tgt_o);
    modport host (output host_o, output host_oe_n, input pin);
    modport target (output tgt_o, output tgt_oe_n, input pin);
endinterface

// *** rtl/bdg_target.sv ***
// Target end of the background debug link: command acknowledge and abort.
// Assumes a synchronous pin level and a command engine on the user side.
`timescale 1ns/1ns
`include "bdg_params.svh"
module bdg_target #(
    parameter int SER_DIV = `BDG_SER_DIV
) (
    input  wire logic    CLK,
    input  wire logic    RESETN,
    bdg_link_if.target   LINK,
    input  wire logic    CMD_DONE,
    input  wire logic    ACCESS_BUSY,
    input  wire logic    LOW_POWER,
    output logic         CMD_VALID,
    output logic         CMD_ABORT,
    output logic         SYNC_DONE
);
    import bdg_pkg::*;

    localparam logic [`BDG_CNT_W-1:0] ABORT_DET = `BDG_CNT_W'((`BDG_ABORT_SER - 1) * SER_DIV);
    localparam logic [`BDG_CNT_W-1:0] CMD_MIN   = `BDG_CNT_W'(`BDG_CMD_MIN_SER * SER_DIV - 1);
    localparam logic [`BDG_CNT_W-1:0] GUARD     = `BDG_CNT_W'(`BDG_GUARD_SER * SER_DIV);
    localparam logic [`BDG_CNT_W-1:0] ACK_LEN   = `BDG_CNT_W'(`BDG_ACK_SER * SER_DIV - 1);
    localparam logic [`BDG_CNT_W-1:0] SPD_LEN   = `BDG_CNT_W'(`BDG_SPEED_SER * SER_DIV - 1);
    localparam logic [`BDG_CNT_W-1:0] REPLY_LEN = `BDG_CNT_W'(`BDG_REPLY_SER * SER_DIV - 1);
    localparam logic [`BDG_CNT_W-1:0] RUN_MAX   = {`BDG_CNT_W{1'b1}};

    bdg_tgt_state_t          state_reg;
    logic [`BDG_CNT_W-1:0]   run_reg;
    logic [`BDG_CNT_W-1:0]   tmr_reg;
    logic                    pin_q_reg;
    logic                    done_reg;
    logic                    o_reg;
    logic                    oe_n_reg;
    logic                    rise;
    logic                    long_low;
    logic                    quiet;

    assign LINK.tgt_o    = o_reg;
    assign LINK.tgt_oe_n = oe_n_reg;

    ////////////////////////////////////////////////////////////////////////////
    // Pin level history.

    // Counts clocks since the last change of the pin, saturating.
    always_ff @(posedge CLK) begin
        if (!RESETN) begin
            pin_q_reg <= 1'b1;
            run_reg   <= '0;
        end else begin
            pin_q_reg <= LINK.pin;
            if (LINK.pin != pin_q_reg) begin
                run_reg <= '0;
            end else if (run_reg != RUN_MAX) begin
                run_reg <= run_reg + 1'b1;
            end
        end
    end

    // Edge, long low and quiet high detection.
    assign rise     = LINK.pin && !pin_q_reg;
    assign long_low = !LINK.pin && !pin_q_reg && (run_reg == ABORT_DET);
    assign quiet    = LINK.pin && pin_q_reg && (run_reg >= GUARD);

    ////////////////////////////////////////////////////////////////////////////
    // Handshake state machine.

    // Accepts commands, drives acknowledges and answers aborts.
    always_ff @(posedge CLK) begin
        if (!RESETN) begin
            state_reg <= T_IDLE;
            tmr_reg   <= '0;
            done_reg  <= 1'b0;
            o_reg     <= 1'b1;
            oe_n_reg  <= 1'b1;
            CMD_VALID <= 1'b0;
            CMD_ABORT <= 1'b0;
            SYNC_DONE <= 1'b0;
        end else begin
            CMD_VALID <= 1'b0;
            CMD_ABORT <= 1'b0;
            SYNC_DONE <= 1'b0;
            if (tmr_reg != '0) begin
                tmr_reg <= tmr_reg - 1'b1;
            end
            unique case (state_reg)
                T_IDLE: begin
                    if (long_low) begin
                        state_reg <= T_SYNC;
                    end else if (rise && run_reg >= CMD_MIN && !LOW_POWER) begin
                        CMD_VALID <= 1'b1;
                        done_reg  <= 1'b0;
                        state_reg <= T_PEND;
                    end
                end
                T_PEND: begin
                    if (long_low) begin
                        CMD_ABORT <= !ACCESS_BUSY;
                        state_reg <= T_SYNC;
                    end else if (LOW_POWER) begin
                        state_reg <= T_IDLE;
                    end else if ((done_reg || CMD_DONE) && quiet) begin
                        o_reg     <= 1'b0;
                        oe_n_reg  <= 1'b0;
                        tmr_reg   <= ACK_LEN;
                        state_reg <= T_ACK;
                    end else if (CMD_DONE) begin
                        done_reg <= 1'b1;
                    end
                end
                T_ACK: begin
                    if (tmr_reg == '0) begin
                        o_reg     <= 1'b1;
                        tmr_reg   <= SPD_LEN;
                        state_reg <= T_SPEED;
                    end
                end
                T_SPEED: begin
                    if (tmr_reg == '0) begin
                        oe_n_reg  <= 1'b1;
                        state_reg <= T_IDLE;
                    end
                end
                T_SYNC: begin
                    if (quiet) begin
                        o_reg     <= 1'b0;
                        oe_n_reg  <= 1'b0;
                        tmr_reg   <= REPLY_LEN;
                        state_reg <= T_REPLY;
                    end
                end
                T_REPLY: begin
                    if (tmr_reg == '0) begin
                        o_reg     <= 1'b1;
                        tmr_reg   <= SPD_LEN;
                        state_reg <= T_RSPEED;
                    end
                end
                T_RSPEED: begin
                    if (tmr_reg == '0) begin
                        oe_n_reg  <= 1'b1;
                        SYNC_DONE <= 1'b1;
                        state_reg <= T_IDLE;
                    end
                end
            endcase
        end
    end
endmodule

// *** sim/bdg_link_monitor.sv ***
// Checker of the background debug wire and the handshake pulses of both ends.
// Assumes the signals of one link interface that joins a host and a target.
`timescale 1ns/1ns
`include "bdg_params.svh"
module bdg_link_monitor #(
    parameter int SER_DIV = `BDG_SER_DIV
) (
    input wire logic CLK,
    input wire logic RESETN,
    input wire logic host_o,
    input wire logic host_oe_n,
    input wire logic tgt_o,
    input wire logic tgt_oe_n,
    input wire logic pin,
    input wire logic conflict,
    input wire logic CMD_VALID,
    input wire logic ACK_SEEN
);
    // Pulse lengths in clocks, scaled from the serial cycle counts.
    localparam int CmdLen   = `BDG_CMD_SER * SER_DIV;
    localparam int AbortLen = `BDG_ABORT_SER * SER_DIV;
    localparam int AckLen   = `BDG_ACK_SER * SER_DIV;
    logic        h_low;
    logic        h_high;
    logic        t_low;
    logic        t_high;
    logic [15:0] hlo_cnt;
    logic [15:0] hhi_cnt;
    logic [15:0] tlo_cnt;
    assign h_low  = !host_oe_n && !host_o;
    assign h_high = !host_oe_n && host_o;
    assign t_low  = !tgt_oe_n && !tgt_o;
    assign t_high = !tgt_oe_n && tgt_o;
    ////////////////////////////////////////////////////////////////////////
    // Run lengths of host low, host speedup and target low drives.
    always_ff @(posedge CLK) begin
        if (!RESETN) begin
            hlo_cnt <= 16'h0000;
            hhi_cnt <= 16'h0000;
            tlo_cnt <= 16'h0000;
        end else begin
            hlo_cnt <= h_low ? hlo_cnt + 16'h0001 : 16'h0000;
            hhi_cnt <= h_high ? hhi_cnt + 16'h0001 : 16'h0000;
            tlo_cnt <= t_low ? tlo_cnt + 16'h0001 : 16'h0000;
        end
    end
    ////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RESETN);
    sequence s_rise;
        $past(pin) && !$past(pin, 2);
    endsequence
    sequence s_long_low;
        hlo_cnt == AbortLen;
    endsequence
    sequence s_reply;
        t_low;
    endsequence
    property p_abort_sync;
        s_long_low |-> ##[1:60] s_reply;
    endproperty
    a_no_conflict:     assert property (!conflict)
        else $error("Speedup driven against a low drive.");
    a_ack_falls_first: assert property ($fell(tgt_oe_n) |-> !tgt_o)
        else $error("Target drive did not start low.");
    a_tgt_high_after:  assert property ($rose(t_high) |-> $past(t_low))
        else $error("Target drove high outside a speedup.");
    a_host_high_after: assert property ($rose(h_high) |-> $past(h_low))
        else $error("Host drove high outside a speedup.");
    a_tgt_low_len:     assert property ((tlo_cnt != 0 && !t_low) |-> tlo_cnt == AckLen)
        else $error("Target low pulse has the wrong length.");
    a_host_low_len:    assert property ((hlo_cnt != 0 && !h_low) |-> (hlo_cnt == CmdLen || hlo_cnt == AbortLen))
        else $error("Host low pulse has the wrong length.");
    a_speedup_len:     assert property ((hhi_cnt != 0 && !h_high) |-> hhi_cnt == SER_DIV)
        else $error("Host speedup has the wrong length.");
    a_abort_sync:      assert property (p_abort_sync)
        else $error("No sync reply after the long low.");
    a_valid_on_rise:   assert property (CMD_VALID |-> s_rise)
        else $error("Command accepted without a rising edge.");
    a_ack_seen_rise:   assert property (ACK_SEEN |-> s_rise)
        else $error("Acknowledge seen without a rising edge.");
endmodule

// *** sim/debug_ack_abort_handshake_tb.sv ***
// Self-checking bench of host and target joined over one debug link.
// Assumes the rtl files compiled first and a 100 MHz clock.
`timescale 1ns/1ns
`include "bdg_params.svh"
module debug_ack_abort_handshake_tb;
    import bdg_pkg::*;
    localparam int D = 2;
    localparam int TMO = 40;
    localparam int LIMIT = 20000;
    logic        clk, resetn, cmd_req, abort_req, cmd_done, access_busy, low_power;
    logic        ready, ack_seen, ack_missing, abort_done, cmd_valid, cmd_abort, sync_done;
    logic [31:0] seed = 32'h000169EF;
    int          num_errors, n_compared, cycles, run;
    int          n_ack, n_miss, n_adone, n_valid, n_cabort, n_sync, n_long, n_ackl, n_tlow;
    int          v, m, t, a, c, s, ad, lg;
    bdg_link_if link ();
    bdg_host #(.SER_DIV(D), .ACK_TMO(TMO), .SYNC_TMO(TMO)) i_bdg_host (.CLK(clk), .RESETN(resetn),
        .LINK(link.host), .CMD_REQ(cmd_req), .ABORT_REQ(abort_req), .READY(ready), .ACK_SEEN(ack_seen),
        .ACK_MISSING(ack_missing), .ABORT_DONE(abort_done));
    bdg_target #(.SER_DIV(D)) i_bdg_target (.CLK(clk), .RESETN(resetn), .LINK(link.target),
        .CMD_DONE(cmd_done), .ACCESS_BUSY(access_busy), .LOW_POWER(low_power), .CMD_VALID(cmd_valid),
        .CMD_ABORT(cmd_abort), .SYNC_DONE(sync_done));
    bdg_link_monitor #(.SER_DIV(D)) i_bdg_link_monitor (.CLK(clk), .RESETN(resetn), .host_o(link.host_o),
        .host_oe_n(link.host_oe_n), .tgt_o(link.tgt_o), .tgt_oe_n(link.tgt_oe_n), .pin(link.pin),
        .conflict(link.conflict), .CMD_VALID(cmd_valid), .ACK_SEEN(ack_seen));
    ////////////////////////////////////////////////////////////////////////
    // Prints the verdict and ends the run.
    task automatic wrap_up;
        if (num_errors == 0 && n_compared > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
        n_compared++;
        if (got !== exp) begin
            num_errors++;
            $display("Error %s expected %0d seen %0d", name, exp, got);
        end
    endtask
    // Waits a bounded time for an event counter to move.
    task automatic wait_inc(ref int cnt, input int base, input string name);
        int k;
        k = 0;
        while (cnt == base && k < 1000) begin
            @(posedge clk);
            k++;
        end
        check(name, 32'h1, 32'(cnt != base));
    endtask
    // Raises one request input for a single clock; no reference to a signal is passed in.
    localparam int P_CMD   = 0;
    localparam int P_ABORT = 1;
    localparam int P_DONE  = 2;
    task automatic pulse(input int which);
        @(posedge clk);
        cmd_req   <= (which == P_CMD);
        abort_req <= (which == P_ABORT);
        cmd_done  <= (which == P_DONE);
        @(posedge clk);
        cmd_req   <= 1'b0;
        abort_req <= 1'b0;
        cmd_done  <= 1'b0;
    endtask
    function automatic logic [3:0] rnd();
        seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
        return seed[3:0];
    endfunction
    // Abort pulses expected: a running access keeps its command alive.
    function automatic logic [31:0] exp_abort(input logic busy);
        return busy ? 32'h0 : 32'h1;
    endfunction
    // One command, a random engine delay, then the acknowledge.
    task automatic run_cmd(input logic [3:0] gap);
        int v0, a0, l0;
        v0 = n_valid;
        a0 = n_ack;
        l0 = n_ackl;
        pulse(P_CMD);
        wait_inc(n_valid, v0, "cmd_valid");
        repeat (gap) @(posedge clk);
        pulse(P_DONE);
        wait_inc(n_ack, a0, "ack_seen");
        check("ack_low_len", 32'h1, 32'(n_ackl - l0));
    endtask
    ////////////////////////////////////////////////////////////////////////
    // Clock of 10 ns period.
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    // Counts handshake pulses, low runs on the wire and the cycle limit.
    always @(posedge clk) begin
        cycles <= cycles + 1;
        n_ack <= n_ack + int'(ack_seen === 1'b1);
        n_miss <= n_miss + int'(ack_missing === 1'b1);
        n_adone <= n_adone + int'(abort_done === 1'b1);
        n_valid <= n_valid + int'(cmd_valid === 1'b1);
        n_cabort <= n_cabort + int'(cmd_abort === 1'b1);
        n_sync <= n_sync + int'(sync_done === 1'b1);
        n_tlow <= n_tlow + int'(link.tgt_oe_n === 1'b0);
        if (link.pin === 1'b0) begin
            run <= run + 1;
        end else begin
            n_long <= n_long + int'(run == `BDG_ABORT_SER * D);
            n_ackl <= n_ackl + int'(run == `BDG_ACK_SER * D);
            run <= 0;
        end
        if (cycles == LIMIT) begin
            num_errors++;
            wrap_up();
        end
    end
    // Main sequence.
    initial begin
        {cmd_req, abort_req, cmd_done, access_busy, low_power, resetn} = 6'h00;
        repeat (6) @(posedge clk);
        resetn <= 1'b1;
        @(posedge clk);
        check("ready", 32'h1, 32'(ready));
        for (int i = 0; i < 4; i++) begin
            run_cmd(rnd());
        end
        // Abort of a pending command, plain and during a running access.
        for (int b = 0; b < 2; b++) begin
            v = n_valid;
            c = n_cabort;
            s = n_sync;
            ad = n_adone;
            a = n_ack;
            lg = n_long;
            access_busy <= b[0];
            pulse(P_CMD);
            wait_inc(n_valid, v, "cmd_valid");
            pulse(P_ABORT);
            repeat (`BDG_ABORT_SER * D + 14) @(posedge clk);
            pulse(P_DONE);
            wait_inc(n_adone, ad, "abort_done");
            wait_inc(n_sync, s, "sync_done");
            check("cmd_abort", exp_abort(b[0]), 32'(n_cabort - c));
            check("long_low", 32'h1, 32'(n_long - lg));
            check("ack_none", 32'h0, 32'(n_ack - a));
            access_busy <= 1'b0;
            run_cmd(rnd());
        end
        // Command discarded by low power entry, then timeout and abort.
        v = n_valid;
        m = n_miss;
        t = n_tlow;
        ad = n_adone;
        s = n_sync;
        pulse(P_CMD);
        wait_inc(n_valid, v, "cmd_valid");
        low_power <= 1'b1;
        pulse(P_DONE);
        wait_inc(n_miss, m, "ack_missing");
        check("tgt_quiet", 32'h0, 32'(n_tlow - t));
        low_power <= 1'b0;
        wait_inc(n_adone, ad, "abort_done");
        wait_inc(n_sync, s, "sync_done");
        run_cmd(rnd());
        wrap_up();
    end
endmodule
